// File: rtl/ccb_pkg.sv
// constants and carrier types for the processor to cipher-port bridge
//
// Behaviour
// - access is address latch then data cycles
// - bit1 low latch, high data, bit0 high
// - respond only low strobe, no high strobe
// - chip select decoded from address bits 2-23
// - latch write passes low strobe to port
// - latch ack after S2, drop after strobe
// - write ack at end of S4, one wait
// - read ack same condition, no wait
// - data strobe follows qualified low strobe
// - cipher clock is processor clock halved
// - cipher clock forced low at acknowledge, data cycles only
// - cipher clock low two cycles at end, data cycles only
// - registered outputs update on falling edge
// - totem and open-drain acks share timing
package ccb_pkg;
  // processor clock rate and the divide ratio of the cipher clock
  localparam int CCB_CPU_CLK_KHZ = 8000;
  localparam int CCB_CIPHER_CLK_KHZ = 4000;
  localparam int CCB_CLK_DIV = CCB_CPU_CLK_KHZ / CCB_CIPHER_CLK_KHZ;
  // cycles the cipher clock stays low at the end of a data cycle
  localparam int CCB_END_LOW_CYCLES = 2;
  // reset values of the registered outputs (strobes and acks are active low)
  localparam logic CCB_RST_CIPHER_CLK = 1'b0;
  localparam logic CCB_RST_ACK_N = 1'b1;
  localparam logic CCB_RST_STROBE_N = 1'b1;

  // processor-side bus inputs; chip select and the strobes are active low
  typedef struct packed {
    logic chip_sel_n;
    logic bus_addr_strobe_n;
    logic low_byte_strobe_n;
    logic high_byte_strobe_n;
    logic read_not_write;
    logic cycle_type_bit;
  } ccb_bus_t;

  // cipher master port outputs
  typedef struct packed {
    logic port_addr_strobe_n;
    logic port_data_strobe_n;
    logic port_chip_select_n;
    logic cipher_clk;
  } ccb_port_t;
endpackage

// File: rtl/ccb_bridge.sv
// bridge from the asynchronous processor bus to the cipher master port
`timescale 1ns/1ps
`default_nettype none
module ccb_bridge
  import ccb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // processor bus, synchronous to clk_sys
  input wire ccb_bus_t bus_in,
  // cipher master port
  output ccb_port_t port_out,
  // acknowledges
  output logic transfer_ack_n,
  output logic ack_open_drain_o,
  output logic ack_open_drain_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the bus qualifiers

  logic sel; // chip select and address strobe both active
  logic low_only; // low lane only, as byte moves to odd addresses give
  logic latch_cyc; // address latch write
  logic data_cyc; // data transfer with low strobe present
  logic data_end; // strobes gone, the tail of a data cycle
  logic ack_nxt;
  logic clk_nxt;
  logic ack_r; // active-high acknowledge state
  logic clk_r;
  logic data_cyc_r; // last sampled cycle was a data transfer
  logic tail_r; // second low cycle of the cipher clock after a data cycle
  logic [2:0] low_run_r; // check helper: length of the current cipher clock low phase

  always_comb
  begin
    // chip select arrives decoded from address bits 2-23 outside
    sel = !bus_in.chip_sel_n && !bus_in.bus_addr_strobe_n;
    low_only = !bus_in.low_byte_strobe_n && bus_in.high_byte_strobe_n;
    latch_cyc = sel && low_only && !bus_in.read_not_write && !bus_in.cycle_type_bit;
    data_cyc = sel && low_only && bus_in.cycle_type_bit;
    data_end = bus_in.bus_addr_strobe_n && bus_in.low_byte_strobe_n && bus_in.high_byte_strobe_n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge: data cycles ack once the low strobe is seen, so writes
  // (strobe late) get one wait state and reads (strobe early) none

  always_comb
  begin
    // latch cycles ack on address strobe alone, the edge after S2
    ack_nxt = data_cyc || (sel && !bus_in.read_not_write && !bus_in.cycle_type_bit);
  end

  // all registered state would take the falling edge of the processor clock;
  // here the system clock stands for that inverted copy
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ack_r <= 1'b0;
      data_cyc_r <= 1'b0;
    end
    else
    begin
      ack_r <= ack_nxt;
      data_cyc_r <= data_cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cipher clock: toggles to halve the rate, forced low on the first acknowledged edge
  // in data cycles and for the end of the cycle, which keeps it low two cycles

  always_comb
  begin
    // new low at ack, and the previous ack-low plus strobe release holds it
    if (!clk_r && !(ack_r && data_end))
      clk_nxt = 1'b1;
    else
      clk_nxt = 1'b0;
    if (data_cyc && !ack_r)
      clk_nxt = 1'b0;
    if (ack_r && data_end)
      clk_nxt = 1'b0;
    if (tail_r)
      clk_nxt = 1'b0;
  end

  // second low cycle at the end of a data transfer; without it the clock would
  // rise one cycle after the strobes and crowd the strobe-to-clock margin
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      tail_r <= 1'b0;
    else
      tail_r <= ack_r && data_end && data_cyc_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      clk_r <= CCB_RST_CIPHER_CLK;
    else
      clk_r <= clk_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered port outputs

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      port_out.port_addr_strobe_n <= CCB_RST_STROBE_N;
      port_out.port_data_strobe_n <= CCB_RST_STROBE_N;
      port_out.port_chip_select_n <= 1'b0;
      port_out.cipher_clk <= CCB_RST_CIPHER_CLK;
      transfer_ack_n <= CCB_RST_ACK_N;
      ack_open_drain_o <= 1'b0;
      ack_open_drain_oe <= 1'b0;
    end
    else
    begin
      port_out.port_addr_strobe_n <= !latch_cyc;
      port_out.port_data_strobe_n <= !data_cyc;
      port_out.port_chip_select_n <= 1'b0;
      port_out.cipher_clk <= clk_nxt;
      transfer_ack_n <= !ack_nxt;
      ack_open_drain_o <= 1'b0;
      ack_open_drain_oe <= ack_nxt && sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_data_sel;
    data_cyc && !ack_r;
  endsequence

  a_ack_pair_equal: assert property (@(posedge clk_sys) disable iff (!rstn)
    ack_open_drain_oe |-> !transfer_ack_n)
    else $error("open-drain ack driven without totem ack");
  a_ack_after_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
    (data_cyc || latch_cyc) |=> !transfer_ack_n)
    else $error("ack missing after selected cycle");
  a_clk_low_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_data_sel |=> !port_out.cipher_clk)
    else $error("cipher clock not low at ack");
  a_clk_end_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ack_r && data_end) |=> !port_out.cipher_clk)
    else $error("cipher clock not held low at cycle end");
  a_clk_toggles: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!data_cyc && !ack_r && !tail_r && !port_out.cipher_clk && clk_r == port_out.cipher_clk) |=> port_out.cipher_clk)
    else $error("cipher clock failed to toggle");
  a_mas_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    latch_cyc |=> !port_out.port_addr_strobe_n)
    else $error("address strobe not passed");
  a_mds_data: assert property (@(posedge clk_sys) disable iff (!rstn)
    !bus_in.high_byte_strobe_n |=> port_out.port_data_strobe_n && port_out.port_addr_strobe_n)
    else $error("strobe passed with high lane active");
  a_mds_qual: assert property (@(posedge clk_sys) disable iff (!rstn)
    data_cyc |=> !port_out.port_data_strobe_n)
    else $error("data strobe not passed");
  a_ack_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
    bus_in.bus_addr_strobe_n |=> transfer_ack_n)
    else $error("ack not dropped after address strobe");
  a_cs_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> !port_out.port_chip_select_n)
    else $error("port chip select not low");

  ////////////////////////////////////////////////////////////////////////////////
  // check helpers and the longer-running checks

  // length of the current low phase of the cipher clock; saturates rather than
  // wraps so a stuck-low clock keeps reporting instead of looking healthy again
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      low_run_r <= 3'h0;
    else if (clk_nxt)
      low_run_r <= 3'h0;
    else if (low_run_r != 3'h7)
      low_run_r <= low_run_r + 3'h1;
  end

  // selected data write whose low strobe has not arrived yet
  sequence s_write_wait;
    sel && bus_in.cycle_type_bit && !bus_in.read_not_write && bus_in.low_byte_strobe_n;
  endsequence

  // first edge of a data read, low strobe already present
  sequence s_read_start;
    data_cyc && bus_in.read_not_write && !ack_r;
  endsequence

  // strobes just released after an acknowledged data cycle
  sequence s_data_tail;
    ack_r && data_end && data_cyc_r;
  endsequence

  // two cipher clock cycles low in a row
  sequence s_two_low;
    !port_out.cipher_clk ##1 !port_out.cipher_clk;
  endsequence

  // a write data cycle waits for the late low strobe, which is what
  // gives the processor its single wait state
  a_write_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_write_wait |=> transfer_ack_n)
    else $error("write acknowledged before low strobe");

  // reads see the low strobe early, so ack and data strobe come
  // together on the first edge with no wait state
  a_read_no_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_start |=> (!transfer_ack_n && !port_out.port_data_strobe_n))
    else $error("read ack or strobe late");

  // after a data cycle the clock stays low for two cycles so its
  // first rising edge keeps clear of the released strobe
  a_end_two_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_data_tail |=> s_two_low)
    else $error("cipher clock not low two cycles at end");

  // the longest legal low phase is a toggled low cycle, the end stretch and a forced
  // low at an immediately following strobe
  a_low_bounded: assert property (@(posedge clk_sys) disable iff (!rstn)
    low_run_r <= CCB_END_LOW_CYCLES + 2)
    else $error("cipher clock stuck low");

  // the high phase is never stretched: dividing by two means a high
  // cycle is always followed by a low one
  a_clk_high_falls: assert property (@(posedge clk_sys) disable iff (!rstn)
    port_out.cipher_clk |=> !port_out.cipher_clk)
    else $error("cipher clock high for two cycles");

  // a latch write produces only the address strobe, never a data
  // strobe, so the register address is not mistaken for data
  a_latch_no_data: assert property (@(posedge clk_sys) disable iff (!rstn)
    latch_cyc |=> port_out.port_data_strobe_n)
    else $error("data strobe in latch cycle");

  // a data cycle must not relatch the register address
  // in the cipher port
  a_data_no_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
    data_cyc |=> port_out.port_addr_strobe_n)
    else $error("address strobe in data cycle");

  // a read with bit 1 low is no legal cycle: no strobe and no ack,
  // so a stray read cannot move the latched address
  a_read_latch_none: assert property (@(posedge clk_sys) disable iff (!rstn)
    (sel && bus_in.read_not_write && !bus_in.cycle_type_bit) |=>
      (port_out.port_addr_strobe_n && port_out.port_data_strobe_n && transfer_ack_n))
    else $error("read latch cycle answered");

  // without the decoded chip select the bridge keeps its acks
  // and port strobes inactive
  a_unselected_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    bus_in.chip_sel_n |=> (transfer_ack_n && !ack_open_drain_oe &&
      port_out.port_addr_strobe_n && port_out.port_data_strobe_n))
    else $error("output active without chip select");

  // both port strobes are released as soon as the
  // low strobe goes away
  a_strobe_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
    bus_in.low_byte_strobe_n |=> (port_out.port_addr_strobe_n && port_out.port_data_strobe_n))
    else $error("port strobe held without low strobe");

  // the shared ack line is only pulled while this device is
  // selected, otherwise it would fight other bus slaves
  a_oe_needs_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
    !sel |=> !ack_open_drain_oe)
    else $error("open-drain ack pulled while unselected");

  // when an ack is due both ack outputs show it
  // on the same edge
  a_ack_pair_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    ack_nxt |=> (!transfer_ack_n && ack_open_drain_oe))
    else $error("ack outputs out of step");

  // a latch write is acknowledged on address strobe alone,
  // without waiting for the low strobe
  a_latch_ack_early: assert property (@(posedge clk_sys) disable iff (!rstn)
    (sel && !bus_in.read_not_write && !bus_in.cycle_type_bit) |=> !transfer_ack_n)
    else $error("latch ack delayed");

  // reset leaves every strobe and ack inactive and the shared
  // ack line floating; checked while reset is applied
  a_reset_idle: assert property (@(posedge clk_sys)
    !rstn |=> (transfer_ack_n && !ack_open_drain_oe &&
      port_out.port_addr_strobe_n && port_out.port_data_strobe_n))
    else $error("outputs active after reset");

  // bit 1 low never produces a data strobe, whatever
  // the other qualifiers show
  a_no_data_bit_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    !bus_in.cycle_type_bit |=> port_out.port_data_strobe_n)
    else $error("data strobe with bit 1 low");

  // bit 1 high never produces an address strobe, whatever
  // the other qualifiers show
  a_no_addr_bit_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    bus_in.cycle_type_bit |=> port_out.port_addr_strobe_n)
    else $error("address strobe with bit 1 high");

endmodule
`default_nettype wire

// File: test/ccb_cipher_model.sv
// cipher port stand-in that counts the strobes it receives
`timescale 1ns/1ps
`default_nettype none
module ccb_cipher_model
  import ccb_pkg::*;
(
  // port from the bridge
  input wire ccb_port_t port_in,
  // strobe counts
  output var int n_addr,
  output var int n_data
);
  initial n_addr = 0;
  initial n_data = 0;
  // register address taken on each address strobe
  always @(negedge port_in.port_addr_strobe_n) n_addr++;
  // one byte moved on each data strobe
  always @(negedge port_in.port_data_strobe_n) n_data++;
endmodule
`default_nettype wire

// File: test/tb_ccb_bridge.sv
// self-checking bench for the processor to cipher-port bridge
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_ccb_bridge;
  import ccb_pkg::*;
  localparam ccb_bus_t IDLE = 6'h3f;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  ccb_bus_t bus_in = IDLE;
  ccb_port_t port_out;
  logic transfer_ack_n, od_o, od_oe, c0;
  logic [1:0] st, st_d = 2'h0, ex;
  logic [1:0] exp_q[$];
  logic [31:0] seed = 32'h62fd_c759;
  int miscompares = 0, n_tests = 0, n_addr, n_data, e_addr = 0, e_data = 0;
  always #5 clk_sys = ~clk_sys;
  ccb_bridge u_ccb_bridge (.clk_sys(clk_sys), .rstn(rstn), .bus_in(bus_in), .port_out(port_out),
    .transfer_ack_n(transfer_ack_n), .ack_open_drain_o(od_o), .ack_open_drain_oe(od_oe));
  ccb_cipher_model u_ccb_cipher_model (.port_in(port_out), .n_addr(n_addr), .n_data(n_data));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one processor byte cycle; odd address, low lane only unless refused
  task automatic access(input logic cs_n, input logic rd, input logic a1, input logic uds_n, input int hold,
    input logic late);
    if (!cs_n && uds_n && (a1 || !rd))
    begin
      exp_q.push_back(a1 ? 2'h2 : 2'h1);
      if (a1) e_data++;
      else e_addr++;
    end
    @(posedge clk_sys);
    bus_in <= {cs_n, 1'b0, late, uds_n, rd, a1};
    if (late)
    begin
      @(posedge clk_sys);
      bus_in.low_byte_strobe_n <= 1'b0;
      #1;
      `CHK("ack_n before low strobe", (cs_n | rd | a1), transfer_ack_n)
    end
    repeat (hold) @(posedge clk_sys);
    bus_in <= IDLE;
    repeat (2)
    begin
      @(posedge clk_sys);
      #1;
      `CHK("ack_n after release", 1'b1, transfer_ack_n)
      `CHK("oe after release", 1'b0, od_oe)
      if (!cs_n && uds_n && a1) `CHK("cipher_clk end", 1'b0, port_out.cipher_clk)
    end
  endtask
  // watches the port strobes and pairs each new one with the oldest note
  always @(posedge clk_sys)
  begin
    #1;
    st = {~port_out.port_data_strobe_n, ~port_out.port_addr_strobe_n};
    if (rstn && st != 2'h0 && st_d == 2'h0)
    begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 2'h0;
      `CHK("strobe", ex, st)
      `CHK("ack_n", 1'b0, transfer_ack_n)
      `CHK("oe", 1'b1, od_oe)
      `CHK("od level", 1'b0, od_o)
      if (st[1]) `CHK("cipher_clk at ack", 1'b0, port_out.cipher_clk)
    end
    st_d = st;
  end
  // watchdog sized well above the expected run of a few microseconds
  initial
  begin
    #50_000;
    miscompares++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK("port reset", 4'hc, port_out)
    `CHK("ack reset", 1'b1, transfer_ack_n)
    `CHK("oe reset", 1'b0, od_oe)
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    c0 = port_out.cipher_clk;
    @(posedge clk_sys);
    #1;
    `CHK("cipher_clk halves", ~c0, port_out.cipher_clk)
    $display("test reset and divider done");
    access(1'b0, 1'b0, 1'b0, 1'b1, 2, 1'b0);
    access(1'b0, 1'b0, 1'b1, 1'b1, 3, 1'b0);
    access(1'b0, 1'b1, 1'b1, 1'b1, 2, 1'b0);
    access(1'b0, 1'b0, 1'b1, 1'b1, 2, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      access(seed[6] & seed[7], seed[0], seed[1], seed[2] | seed[3], 2 + int'(seed[5:4]), seed[8]);
    end
    `CHK("addr strobes", e_addr, n_addr)
    `CHK("data strobes", e_data, n_data)
    `CHK("notes left", 0, exp_q.size())
    $display("test access sequence done");
    finish_test;
  end
endmodule
`default_nettype wire
